// File: hdl/pspc_defines.svh
// constants shared by the slave port device end and the external processor end
// assumes inclusion by bare name from files under hdl/
`ifndef PSPC_DEFINES_SVH
`define PSPC_DEFINES_SVH
// =============================================
// widths
`define PSPC_DW          8
`define PSPC_CW          3
`define PSPC_AW          8
`define PSPC_IW          3
// =============================================
// device register offsets
`define PSPC_OFF_DPIN    8'h00
`define PSPC_OFF_DLAT    8'h04
`define PSPC_OFF_DDIR    8'h08
`define PSPC_OFF_ECTL    8'h0C
`define PSPC_OFF_EPIN    8'h10
`define PSPC_OFF_ELAT    8'h14
`define PSPC_OFF_ACFG    8'h18
`define PSPC_OFF_ISTS    8'h1C
`define PSPC_OFF_IMSK    8'h20
// =============================================
// control_port_direction_status fields
`define PSPC_B_IBF       7
`define PSPC_B_OBF       6
`define PSPC_B_INBOUND_OVERRUN      5
`define PSPC_B_MODE      4
// =============================================
// reset values and the all-digital analog configuration value
`define PSPC_RST_DDIR    8'hFF
`define PSPC_RST_EDIR    3'h7
`define PSPC_RST_ACFG    3'h0
`define PSPC_ACFG_DIG    3'h7
// =============================================
// interrupt status bits
`define PSPC_I_WR        0
`define PSPC_I_RD        1
`define PSPC_I_OV        2
// =============================================
// bus responses
`define PSPC_OKAY        2'h0
`define PSPC_SLVERR      2'h2
// =============================================
// host register offsets and fields, and the default strobe hold count
`define PSPC_H_CMD       8'h00
`define PSPC_H_STAT      8'h04
`define PSPC_H_RDAT      8'h08
`define PSPC_H_CTRL      8'h0C
`define PSPC_H_B_RNW     8
`define PSPC_H_B_BUSY    0
`define PSPC_H_B_DONE    1
`define PSPC_H_HOLD      8
`endif

// File: hdl/pspc_pkg.sv
// types shared by both ends of the slave port link, and the host end's strobe sequencer states
// assumes pspc_defines.svh on the include path
`include "pspc_defines.svh"
package pspc_pkg;
   typedef logic [`PSPC_DW-1:0] pspc_byte_t;
   typedef logic [`PSPC_CW-1:0] pspc_ctl_t;
   typedef enum logic [3:0]
   {
      HS_IDLE   = 4'b0001,
      HS_SETUP  = 4'b0010,
      HS_STROBE = 4'b0100,
      HS_RECOV  = 4'b1000
   } pspc_hstate_e;
endpackage

// File: hdl/pspc_link_if.sv
// pins between the device end and the external processor end
// assumes both ends clocked by one aclk; undriven pins float high
interface pspc_link_if;
   pspc_pkg::pspc_byte_t dev_d_o;
   pspc_pkg::pspc_byte_t dev_d_oe;
   pspc_pkg::pspc_ctl_t  dev_e_o;
   pspc_pkg::pspc_ctl_t  dev_e_oe;
   pspc_pkg::pspc_byte_t hst_d_o;
   pspc_pkg::pspc_byte_t hst_d_oe;
   pspc_pkg::pspc_ctl_t  hst_e_o;
   pspc_pkg::pspc_ctl_t  hst_e_oe;
   pspc_pkg::pspc_byte_t d_lvl;
   pspc_pkg::pspc_ctl_t  e_lvl;
   // =============================================
   // wire resolution: device wins a clash, pull-up when idle
   assign d_lvl = (dev_d_oe & dev_d_o) | (~dev_d_oe & hst_d_oe & hst_d_o)
                | (~dev_d_oe & ~hst_d_oe);
   assign e_lvl = (dev_e_oe & dev_e_o) | (~dev_e_oe & hst_e_oe & hst_e_o)
                | (~dev_e_oe & ~hst_e_oe);
   modport dev_mp (output dev_d_o, dev_d_oe, dev_e_o, dev_e_oe, input d_lvl, e_lvl);
   modport hst_mp (output hst_d_o, hst_d_oe, hst_e_o, hst_e_oe, input d_lvl, e_lvl);
endinterface

// File: hdl/pspc_device.sv
// device end: data port, control port and parallel slave port, AXI4-Lite registers
// assumes one clock aclk; link pins sampled on aclk, strobes synchronised here
// Operation
// R1: three control pins, each direction, latch, readback
// R2: direction one tristates, zero drives latch
// R3: reset: control pins analog, direction 0x07
// R4: own latch register; read-modify-write uses latch
// R5: analog control pins read as zero
// R6: software keeps analog pins as inputs
// R7: bit 7 flags unread externally written word
// R8: bit 6 flags word not yet read externally
// R9: bit 5 flags overrun until software clears
// R10: bit 4 selects slave port mode
// R11: bit 3 always reads zero
// R12: external processor reads/writes data latch asynchronously
// R13: pins 0,1,2 are read, write, select
// R14: write when select and write first low
// R15: read when select and read first low
// R16: software sets pins input and digital first
// R17: data direction resets to all ones
// R18: strobes synchronised before joint-low detection
// R19: core read clears inbound, write sets outbound
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`include "pspc_defines.svh"
module pspc_device
#(
   parameter int DW = `PSPC_DW,
   parameter int CW = `PSPC_CW,
   parameter int AW = `PSPC_AW
)
(
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic [AW-1:0] s_awaddr,
   input  wire logic          s_awvalid,
   output      logic          s_awready,
   input  wire logic [31:0]   s_wdata,
   input  wire logic [3:0]    s_wstrb,
   input  wire logic          s_wvalid,
   output      logic          s_wready,
   output      logic [1:0]    s_bresp,
   output      logic          s_bvalid,
   input  wire logic          s_bready,
   input  wire logic [AW-1:0] s_araddr,
   input  wire logic          s_arvalid,
   output      logic          s_arready,
   output      logic [31:0]   s_rdata,
   output      logic [1:0]    s_rresp,
   output      logic          s_rvalid,
   input  wire logic          s_rready,
   output      logic          irq,
   pspc_link_if.dev_mp        lnk
);
   // =============================================
   // elaboration check
   generate
      if (DW != `PSPC_DW || CW != `PSPC_CW || AW < 6)
      begin : g_bad
         $error("pspc_device: field layout needs DW=8, CW=3, AW>=6");
      end
   endgenerate

   function automatic logic is_mapped(input logic [AW-1:0] a);
      is_mapped = (a <= AW'(`PSPC_OFF_IMSK)) && (a[1:0] == 2'h0);
   endfunction

   // =============================================
   // state
   pspc_pkg::pspc_byte_t dlat;
   pspc_pkg::pspc_byte_t ddir;
   pspc_pkg::pspc_byte_t ibuf;
   pspc_pkg::pspc_ctl_t  elat;
   pspc_pkg::pspc_ctl_t  edir;
   pspc_pkg::pspc_ctl_t  acfg;
   pspc_pkg::pspc_ctl_t  sync1;
   pspc_pkg::pspc_ctl_t  sync2;
   logic                 inbound_full;
   logic                 outbound_full;
   logic                 inbound_overrun;
   logic                 mode;
   logic                 wr_q;
   logic                 rd_q;
   logic [`PSPC_IW-1:0]  ists;
   logic [`PSPC_IW-1:0]  imsk;
   logic                 aw_got;
   logic                 w_got;
   logic [AW-1:0]        aw_a;
   logic [31:0]          w_d;
   logic                 w_s0;

   // =============================================
   // AXI4-Lite handshakes
   logic do_wr;
   logic ar_hs;
   logic wr_sel;
   assign s_awready = ~aw_got & ~s_bvalid;
   assign s_wready  = ~w_got & ~s_bvalid;
   assign s_arready = ~s_rvalid;
   assign do_wr     = aw_got & w_got;
   assign ar_hs     = s_arvalid & s_arready;
   assign wr_sel    = do_wr & w_s0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got   <= 1'b0;
         w_got    <= 1'b0;
         aw_a     <= '0;
         w_d      <= 32'h0000_0000;
         w_s0     <= 1'b0;
         s_bvalid <= 1'b0;
         s_bresp  <= `PSPC_OKAY;
      end
      else
      begin
         if (s_awvalid && s_awready)
         begin
            aw_got <= 1'b1;
            aw_a   <= s_awaddr;
         end
         if (s_wvalid && s_wready)
         begin
            w_got <= 1'b1;
            w_d   <= s_wdata;
            w_s0  <= s_wstrb[0];
         end
         if (do_wr)
         begin
            aw_got   <= 1'b0;
            w_got    <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp  <= is_mapped(aw_a) ? `PSPC_OKAY : `PSPC_SLVERR;
         end
         else if (s_bready)
         begin
            s_bvalid <= 1'b0;
         end
      end
   end

   // =============================================
   // register write decode and data port read detection
   logic wr_dpin;
   logic wr_dlat;
   logic wr_ddir;
   logic wr_ectl;
   logic wr_elat;
   logic wr_acfg;
   logic wr_ists;
   logic wr_imsk;
   logic rd_dpin;
   assign wr_dpin = wr_sel && aw_a == AW'(`PSPC_OFF_DPIN);
   assign wr_dlat = wr_sel && aw_a == AW'(`PSPC_OFF_DLAT);
   assign wr_ddir = wr_sel && aw_a == AW'(`PSPC_OFF_DDIR);
   assign wr_ectl = wr_sel && aw_a == AW'(`PSPC_OFF_ECTL);
   assign wr_elat = wr_sel && (aw_a == AW'(`PSPC_OFF_ELAT) || aw_a == AW'(`PSPC_OFF_EPIN));
   assign wr_acfg = wr_sel && aw_a == AW'(`PSPC_OFF_ACFG);
   assign wr_ists = wr_sel && aw_a == AW'(`PSPC_OFF_ISTS);
   assign wr_imsk = wr_sel && aw_a == AW'(`PSPC_OFF_IMSK);
   assign rd_dpin = ar_hs && s_araddr == AW'(`PSPC_OFF_DPIN); // [R19]

   // =============================================
   // strobe synchroniser and joint-low detection
   logic wr_act;
   logic rd_act;
   logic ext_wr;
   logic ext_rd_end;
   logic ovr;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1 <= 3'h7;
         sync2 <= 3'h7;
         wr_q  <= 1'b0;
         rd_q  <= 1'b0;
      end
      else
      begin
         sync1 <= lnk.e_lvl; // [R18]
         sync2 <= sync1; // [R18]
         wr_q  <= wr_act;
         rd_q  <= rd_act;
      end
   end
   // pin 0 read, pin 1 write, pin 2 select, all active low
   assign wr_act     = mode & ~sync2[2] & ~sync2[1]; // [R13]
   assign rd_act     = mode & ~sync2[2] & ~sync2[0]; // [R13]
   assign ext_wr     = wr_act & ~wr_q; // [R14]
   assign ext_rd_end = rd_q & ~rd_act; // [R15]
   // a core read in the same cycle frees the buffer for the new word
   assign ovr        = ext_wr & inbound_full & ~rd_dpin; // [R9]

   // =============================================
   // port and slave port registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dlat <= 8'h00;
         ddir <= `PSPC_RST_DDIR; // [R17]
         ibuf <= 8'h00;
         elat <= 3'h0;
         edir <= `PSPC_RST_EDIR; // [R3]
         acfg <= `PSPC_RST_ACFG; // [R3]
         mode <= 1'b0;
         inbound_full  <= 1'b0;
         outbound_full  <= 1'b0;
         inbound_overrun <= 1'b0;
         ists <= 3'h0;
         imsk <= 3'h0;
      end
      else
      begin
         if (wr_dpin || wr_dlat)
            dlat <= w_d[DW-1:0]; // [R4]
         if (wr_ddir)
            ddir <= w_d[DW-1:0];
         if (wr_elat)
            elat <= w_d[CW-1:0]; // [R4]
         if (wr_acfg)
            acfg <= w_d[CW-1:0];
         if (wr_ectl)
         begin
            edir <= w_d[CW-1:0]; // [R1]
            mode <= w_d[`PSPC_B_MODE]; // [R10]
         end
         if (ext_wr && (!inbound_full || rd_dpin))
            ibuf <= lnk.d_lvl; // [R12]
         // sets take priority over clears
         if (ext_wr)
            inbound_full <= 1'b1; // [R7]
         else if (rd_dpin)
            inbound_full <= 1'b0; // [R19]
         if (wr_dpin && mode)
            outbound_full <= 1'b1; // [R19]
         else if (ext_rd_end)
            outbound_full <= 1'b0; // [R8]
         if (ovr)
            inbound_overrun <= 1'b1; // [R9]
         else if (wr_ectl && !w_d[`PSPC_B_INBOUND_OVERRUN])
            inbound_overrun <= 1'b0; // [R9]
         if (wr_imsk)
            imsk <= w_d[`PSPC_IW-1:0];
         ists <= (ists & ~(wr_ists ? w_d[`PSPC_IW-1:0] : 3'h0))
               | {ovr, ext_rd_end, ext_wr};
      end
   end

   // =============================================
   // read mux
   logic                 ctl_dig;
   pspc_pkg::pspc_byte_t ectl_v;
   pspc_pkg::pspc_ctl_t  epin_v;
   pspc_pkg::pspc_byte_t dpin_v;
   pspc_pkg::pspc_byte_t rmux;
   assign ctl_dig = (acfg == `PSPC_ACFG_DIG);
   assign epin_v  = ctl_dig ? lnk.e_lvl : 3'h0; // [R5]
   assign dpin_v  = mode ? ibuf : lnk.d_lvl; // [R12]
   assign ectl_v  = {inbound_full, outbound_full, inbound_overrun, mode, 1'b0, edir}; // [R11]
   assign rmux =
      (s_araddr == AW'(`PSPC_OFF_DPIN)) ? dpin_v :
      (s_araddr == AW'(`PSPC_OFF_DLAT)) ? dlat :
      (s_araddr == AW'(`PSPC_OFF_DDIR)) ? ddir :
      (s_araddr == AW'(`PSPC_OFF_ECTL)) ? ectl_v :
      (s_araddr == AW'(`PSPC_OFF_EPIN)) ? {5'h00, epin_v} :
      (s_araddr == AW'(`PSPC_OFF_ELAT)) ? {5'h00, elat} :
      (s_araddr == AW'(`PSPC_OFF_ACFG)) ? {5'h00, acfg} :
      (s_araddr == AW'(`PSPC_OFF_ISTS)) ? {5'h00, ists} :
      (s_araddr == AW'(`PSPC_OFF_IMSK)) ? {5'h00, imsk} : 8'h00;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_rvalid <= 1'b0;
         s_rdata  <= 32'h0000_0000;
         s_rresp  <= `PSPC_OKAY;
      end
      else if (ar_hs)
      begin
         s_rvalid <= 1'b1;
         s_rdata  <= {24'h00_0000, rmux};
         s_rresp  <= is_mapped(s_araddr) ? `PSPC_OKAY : `PSPC_SLVERR;
      end
      else if (s_rready)
      begin
         s_rvalid <= 1'b0;
      end
   end

   // =============================================
   // pin drivers
   // direction bits keep governing control drivers even in slave mode
   assign lnk.dev_e_o  = elat; // [R2]
   assign lnk.dev_e_oe = ~edir; // [R2]
   assign lnk.dev_d_o  = dlat; // [R15]
   assign lnk.dev_d_oe = mode ? {DW{rd_act}} : ~ddir; // [R15]
   assign irq          = |(ists & imsk);
endmodule

// File: hdl/pspc_host.sv
// external processor end: drives select, read and write strobes and the data bus
// assumes one clock aclk shared in simulation; commands arrive over AXI4-Lite
`include "pspc_defines.svh"
module pspc_host
#(
   parameter int DW   = `PSPC_DW,
   parameter int AW   = `PSPC_AW,
   parameter int HOLD = `PSPC_H_HOLD
)
(
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic [AW-1:0] s_awaddr,
   input  wire logic          s_awvalid,
   output      logic          s_awready,
   input  wire logic [31:0]   s_wdata,
   input  wire logic [3:0]    s_wstrb,
   input  wire logic          s_wvalid,
   output      logic          s_wready,
   output      logic [1:0]    s_bresp,
   output      logic          s_bvalid,
   input  wire logic          s_bready,
   input  wire logic [AW-1:0] s_araddr,
   input  wire logic          s_arvalid,
   output      logic          s_arready,
   output      logic [31:0]   s_rdata,
   output      logic [1:0]    s_rresp,
   output      logic          s_rvalid,
   input  wire logic          s_rready,
   pspc_link_if.hst_mp        lnk
);
   localparam int CNTW = $clog2(HOLD + 1);
   generate
      if (DW != `PSPC_DW || HOLD < 4 || AW < 4)
      begin : g_bad
         $error("pspc_host: needs DW=8, HOLD>=4, AW>=4");
      end
   endgenerate

   // =============================================
   // AXI4-Lite slave
   logic          aw_got;
   logic          w_got;
   logic [AW-1:0] aw_a;
   logic [31:0]   w_d;
   logic          w_s0;
   logic          do_wr;
   logic          ar_hs;
   logic          wr_cmd;
   logic          wr_stat;
   logic          wr_ctrl;
   assign s_awready = ~aw_got & ~s_bvalid;
   assign s_wready  = ~w_got & ~s_bvalid;
   assign s_arready = ~s_rvalid;
   assign do_wr     = aw_got & w_got;
   assign ar_hs     = s_arvalid & s_arready;
   assign wr_cmd    = do_wr && w_s0 && aw_a == AW'(`PSPC_H_CMD);
   assign wr_stat   = do_wr && w_s0 && aw_a == AW'(`PSPC_H_STAT);
   assign wr_ctrl   = do_wr && w_s0 && aw_a == AW'(`PSPC_H_CTRL);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got   <= 1'b0;
         w_got    <= 1'b0;
         aw_a     <= '0;
         w_d      <= 32'h0000_0000;
         w_s0     <= 1'b0;
         s_bvalid <= 1'b0;
         s_bresp  <= `PSPC_OKAY;
      end
      else
      begin
         if (s_awvalid && s_awready)
         begin
            aw_got <= 1'b1;
            aw_a   <= s_awaddr;
         end
         if (s_wvalid && s_wready)
         begin
            w_got <= 1'b1;
            w_d   <= s_wdata;
            w_s0  <= s_wstrb[0];
         end
         if (do_wr)
         begin
            aw_got   <= 1'b0;
            w_got    <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp  <= (aw_a <= AW'(`PSPC_H_CTRL)) ? `PSPC_OKAY : `PSPC_SLVERR;
         end
         else if (s_bready)
         begin
            s_bvalid <= 1'b0;
         end
      end
   end

   // =============================================
   // strobe sequencer
   pspc_pkg::pspc_hstate_e state;
   pspc_pkg::pspc_byte_t   wdat;
   pspc_pkg::pspc_byte_t   rdat;
   logic [CNTW-1:0]        cnt;
   logic                   rnw;
   logic                   drive;
   logic                   done;
   logic                   en;
   logic                   cs_n;
   logic                   wr_n;
   logic                   rd_n;
   logic                   last;
   logic                   start;
   assign last  = (cnt == CNTW'(HOLD - 1));
   assign start = wr_cmd && state == pspc_pkg::HS_IDLE;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= pspc_pkg::HS_IDLE;
         cnt   <= '0;
         {cs_n, wr_n, rd_n} <= 3'h7;
         {rnw, drive, en}   <= 3'h0;
         wdat  <= 8'h00;
         rdat  <= 8'h00;
      end
      else
      begin
         if (wr_ctrl)
            en <= w_d[0];
         unique case (state)
            pspc_pkg::HS_IDLE:
               if (start)
               begin
                  rnw   <= w_d[`PSPC_H_B_RNW];
                  wdat  <= w_d[DW-1:0];
                  drive <= ~w_d[`PSPC_H_B_RNW];
                  state <= pspc_pkg::HS_SETUP;
               end
            pspc_pkg::HS_SETUP:
            begin
               cs_n  <= 1'b0; // [R14] [R15]
               wr_n  <= rnw;
               rd_n  <= ~rnw;
               cnt   <= '0;
               state <= pspc_pkg::HS_STROBE;
            end
            pspc_pkg::HS_STROBE:
            begin
               cnt <= cnt + CNTW'(1);
               if (last)
               begin
                  {cs_n, wr_n, rd_n} <= 3'h7;
                  if (rnw)
                     rdat <= lnk.d_lvl;
                  cnt   <= '0;
                  state <= pspc_pkg::HS_RECOV;
               end
            end
            pspc_pkg::HS_RECOV:
            begin
               drive <= 1'b0;
               cnt   <= cnt + CNTW'(1);
               if (last)
                  state <= pspc_pkg::HS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         done <= 1'b0;
      else if (state == pspc_pkg::HS_RECOV && last)
         done <= 1'b1;
      else if (wr_stat && w_d[`PSPC_H_B_DONE])
         done <= 1'b0;
   end

   // =============================================
   // read mux and pins
   logic [7:0] rmux;
   assign rmux =
      (s_araddr == AW'(`PSPC_H_STAT)) ? {6'h00, done, state != pspc_pkg::HS_IDLE} :
      (s_araddr == AW'(`PSPC_H_RDAT)) ? rdat :
      (s_araddr == AW'(`PSPC_H_CTRL)) ? {7'h00, en} : 8'h00;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_rvalid <= 1'b0;
         s_rdata  <= 32'h0000_0000;
         s_rresp  <= `PSPC_OKAY;
      end
      else if (ar_hs)
      begin
         s_rvalid <= 1'b1;
         s_rdata  <= {24'h00_0000, rmux};
         s_rresp  <= (s_araddr <= AW'(`PSPC_H_CTRL)) ? `PSPC_OKAY : `PSPC_SLVERR;
      end
      else if (s_rready)
      begin
         s_rvalid <= 1'b0;
      end
   end

   assign lnk.hst_e_o  = {cs_n, wr_n, rd_n};
   assign lnk.hst_e_oe = {3{en}};
   assign lnk.hst_d_o  = wdat;
   assign lnk.hst_d_oe = {DW{drive}};
endmodule

// File: bench/pspc_link_sva.sv
// checker for the pins between the device end and the external processor end
// assumes the link signals of one pspc_link_if; slave mode set whenever strobes move
module pspc_link_sva
(
   input wire logic                 aclk,
   input wire logic                 aresetn,
   input wire pspc_pkg::pspc_byte_t dev_d_o,
   input wire pspc_pkg::pspc_byte_t dev_d_oe,
   input wire pspc_pkg::pspc_byte_t hst_d_o,
   input wire pspc_pkg::pspc_byte_t hst_d_oe,
   input wire pspc_pkg::pspc_ctl_t  hst_e_o,
   input wire pspc_pkg::pspc_ctl_t  e_lvl
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // =============================================
   // decoded pin states
   wire rd_lo = !e_lvl[0] && !e_lvl[2];
   wire wr_lo = !e_lvl[1] && !e_lvl[2];
   wire drv   = dev_d_oe == 8'hff;
   // =============================================
   // assertions
   a_read_drive_late: assert property ($rose(drv) |-> $past(rd_lo, 1) && $past(rd_lo, 2))
      else $error("data bus driven before strobes passed the synchronizer");
   a_read_drive_hold: assert property (drv && rd_lo |=> drv)
      else $error("data bus released while read strobes low");
   a_read_release: assert property ($fell(drv) |-> !$past(rd_lo, 1) && !$past(rd_lo, 2))
      else $error("data bus released too early after read strobes");
   a_read_latency: assert property (rd_lo [*5] |-> drv)
      else $error("read strobes low without data on the bus");
   a_write_no_drive: assert property (wr_lo && e_lvl[0] |-> dev_d_oe == 8'h00)
      else $error("device drives data bus during external write");
   a_strobes_together: assert property ($fell(hst_e_o[2]) |-> !hst_e_o[1] || !hst_e_o[0])
      else $error("select asserted without read or write strobe");
   a_write_data_held: assert property (
      !hst_e_o[1] && !hst_e_o[2] |-> hst_d_oe == 8'hff && $stable(hst_d_o))
      else $error("write data not stable while write strobes low");
   a_read_data_held: assert property (drv && $past(drv) |-> $stable(dev_d_o))
      else $error("read data changed while presented");
   cover property (wr_lo [*3]);
   cover property ($rose(drv));
   cover property ($fell(drv));
endmodule

// File: bench/test_parallel_slave_port_ctrl.sv
// testbench: device end and external processor end joined by one link
// assumes both ends driven over AXI4-Lite by this bench, one 200 MHz clock
`include "pspc_defines.svh"
module test_parallel_slave_port_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [1:0]  awv = 2'h0, wv = 2'h0, bre = 2'h0, arv = 2'h0, rre = 2'h0;
   logic [1:0]  awr, wrd, bv, arr, rv;
   logic [7:0]  awa [2] = '{8'h00, 8'h00};
   logic [7:0]  ara [2] = '{8'h00, 8'h00};
   logic [31:0] wd [2] = '{32'h0000_0000, 32'h0000_0000};
   logic [31:0] rdt [2];
   logic [1:0]  br [2];
   logic [1:0]  rr [2];
   logic        irq;
   int          n_errors = 0;
   int          comparisons = 0;
   always #2.5 aclk = ~aclk;
   // =============================================
   // both ends and the checker
   pspc_link_if u_pspc_link_if ();
   pspc_device u_pspc_device (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awa[0]),
      .s_awvalid(awv[0]), .s_awready(awr[0]), .s_wdata(wd[0]), .s_wstrb(4'h1),
      .s_wvalid(wv[0]), .s_wready(wrd[0]), .s_bresp(br[0]), .s_bvalid(bv[0]),
      .s_bready(bre[0]), .s_araddr(ara[0]), .s_arvalid(arv[0]), .s_arready(arr[0]),
      .s_rdata(rdt[0]), .s_rresp(rr[0]), .s_rvalid(rv[0]), .s_rready(rre[0]), .irq(irq),
      .lnk(u_pspc_link_if.dev_mp));
   pspc_host u_pspc_host (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awa[1]),
      .s_awvalid(awv[1]), .s_awready(awr[1]), .s_wdata(wd[1]), .s_wstrb(4'h1),
      .s_wvalid(wv[1]), .s_wready(wrd[1]), .s_bresp(br[1]), .s_bvalid(bv[1]),
      .s_bready(bre[1]), .s_araddr(ara[1]), .s_arvalid(arv[1]), .s_arready(arr[1]),
      .s_rdata(rdt[1]), .s_rresp(rr[1]), .s_rvalid(rv[1]), .s_rready(rre[1]),
      .lnk(u_pspc_link_if.hst_mp));
   pspc_link_sva u_pspc_link_sva (.aclk(aclk), .aresetn(aresetn),
      .dev_d_o(u_pspc_link_if.dev_d_o), .dev_d_oe(u_pspc_link_if.dev_d_oe),
      .hst_d_o(u_pspc_link_if.hst_d_o), .hst_d_oe(u_pspc_link_if.hst_d_oe),
      .hst_e_o(u_pspc_link_if.hst_e_o), .e_lvl(u_pspc_link_if.e_lvl));
   // =============================================
   // bus tasks; h selects device (0) or host (1)
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input int h, input logic [7:0] a, input logic [8:0] d);
      @(posedge aclk);
      awa[h] <= a;
      wd[h] <= {23'h0, d};
      awv[h] <= 1'b1;
      wv[h] <= 1'b1;
      bre[h] <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (awv[h] && awr[h]) awv[h] <= 1'b0;
         if (wv[h] && wrd[h]) wv[h] <= 1'b0;
         if (bv[h]) break;
      end
      bre[h] <= 1'b0;
      chk({30'h0, br[h]}, {30'h0, `PSPC_OKAY});
   endtask
   task automatic rd(input int h, input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      ara[h] <= a;
      arv[h] <= 1'b1;
      rre[h] <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (arv[h] && arr[h]) arv[h] <= 1'b0;
         if (rv[h]) break;
      end
      d = rdt[h];
      r = rr[h];
      rre[h] <= 1'b0;
   endtask
   task automatic rc(input int h, input logic [7:0] a, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(h, a, d, r);
      chk(d, {24'h0, e});
   endtask
   // one external transfer through the host end, then clear its done flag
   task automatic hop(input logic [8:0] cmd);
      logic [31:0] s;
      logic [1:0]  r;
      wr(1, `PSPC_H_CMD, cmd);
      do rd(1, `PSPC_H_STAT, s, r);
      while (s[`PSPC_H_B_DONE] !== 1'b1);
      wr(1, `PSPC_H_STAT, 9'h002);
   endtask
   task automatic final_report();
      $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // =============================================
   // tests
   initial
   begin
      logic [31:0] d;
      logic [1:0]  r;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rc(0, `PSPC_OFF_DDIR, 8'hff);
      rc(0, `PSPC_OFF_ECTL, 8'h07);
      rc(0, `PSPC_OFF_EPIN, 8'h00);
      rd(0, 8'h24, d, r);
      chk({30'h0, r}, {30'h0, `PSPC_SLVERR});
      $display("reset test done");
      wr(0, `PSPC_OFF_ACFG, 9'h007);
      wr(0, `PSPC_OFF_ELAT, 9'h005);
      wr(0, `PSPC_OFF_ECTL, 9'h00f);
      rc(0, `PSPC_OFF_ECTL, 8'h07);
      wr(0, `PSPC_OFF_ECTL, 9'h000);
      rc(0, `PSPC_OFF_EPIN, 8'h05);
      wr(0, `PSPC_OFF_ECTL, 9'h007);
      rc(0, `PSPC_OFF_EPIN, 8'h07);
      rc(0, `PSPC_OFF_ELAT, 8'h05);
      wr(0, `PSPC_OFF_ACFG, 9'h000);
      rc(0, `PSPC_OFF_EPIN, 8'h00);
      $display("control port test done");
      wr(0, `PSPC_OFF_ACFG, 9'h007);
      wr(0, `PSPC_OFF_ECTL, 9'h017);
      rc(0, `PSPC_OFF_ECTL, 8'h17);
      wr(1, `PSPC_H_CTRL, 9'h001);
      hop(9'h0a5);
      rc(0, `PSPC_OFF_ECTL, 8'h97);
      rc(0, `PSPC_OFF_ISTS, 8'h01);
      chk(32'(irq), 32'h0000_0000);
      wr(0, `PSPC_OFF_IMSK, 9'h007);
      chk(32'(irq), 32'h0000_0001);
      hop(9'h03c);
      rc(0, `PSPC_OFF_ECTL, 8'hb7);
      rc(0, `PSPC_OFF_DPIN, 8'ha5);
      rc(0, `PSPC_OFF_ECTL, 8'h37);
      wr(0, `PSPC_OFF_ECTL, 9'h017);
      rc(0, `PSPC_OFF_ECTL, 8'h17);
      rc(0, `PSPC_OFF_ISTS, 8'h05);
      wr(0, `PSPC_OFF_ISTS, 9'h007);
      rc(0, `PSPC_OFF_ISTS, 8'h00);
      chk(32'(irq), 32'h0000_0000);
      $display("external write test done");
      wr(0, `PSPC_OFF_DPIN, 9'h05a);
      rc(0, `PSPC_OFF_ECTL, 8'h57);
      hop(9'h100);
      rc(1, `PSPC_H_RDAT, 8'h5a);
      rc(0, `PSPC_OFF_ECTL, 8'h17);
      rc(0, `PSPC_OFF_ISTS, 8'h02);
      $display("external read test done");
      final_report();
   end
   initial
   begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      final_report();
   end
endmodule
